// ===== rtl/tcpwm_timer.sv
// Three-channel pulse-width timer with register port and pin muxing
// What this block does
// - Three identical channels, each with control, duty, counter and output pin.
// - Counter steps once per selected clock pulse, 0x00 to 0xF9, then wraps.
// - Enable bit 0 holds counter at 0x00, stopped, pulse output disabled.
// - Enable bit 7 set runs the counter; the channel drives the pin when pulse routing is on and serial routing off.
// - Prescale code 0..7 selects divide by 2, 8, 32, 128, 256, 1024, 2048, 4096.
// - Period is 250 counting-clock periods, one step is 1/250 duty.
// - Duty 0x02 and above sets internal pulse when counter steps 0x00 to 0x01.
// - Internal pulse returns to 0 when counter steps to the duty value.
// - Duty zero holds internal pulse at 0 all period.
// - Duty 0xFA to 0xFF holds internal pulse at 1.
// - Duty written while running takes effect after counter wraps 0xF9 to 0x00.
// - Duty written while stopped takes effect at once.
// - Duty read returns the active value, not the pending one.
// - Polarity bit 6 clear gives high for 1; set inverts the pin.
// - Control bits 5 to 3 ignore writes and read as 1.
// - Reset and standby set control 0x38, duty 0xFF, counter 0x00.
// - Disabled channel pin behaves as an ordinary port pin.
module tcpwm_timer #(
    parameter int PRESC_W = tcpwm_pkg::PRESC_W
) (
    input wire logic CLOCK,
    input wire logic RST_B,
    input wire logic STANDBY,
    input wire logic [15:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    input wire logic PORT9_PULSE_ROUTE_EN,
    input wire logic PORT9_SERIAL_ROUTE_EN,
    input wire logic [2:0] PORT9_DATA,
    input wire logic [2:0] PORT9_DIR,
    output logic PULSE_OUT_CH1,
    output logic PULSE_OE_CH1,
    output logic PULSE_OUT_CH2,
    output logic PULSE_OE_CH2,
    output logic PULSE_OUT_CH3,
    output logic PULSE_OE_CH3
);

    localparam int NCH = tcpwm_pkg::NUM_CH;

    // Shift amount for a prescale select code
    function automatic logic [3:0] div_log2(input logic [2:0] sel);
        logic [3:0] k;
        k = tcpwm_pkg::DIV_LOG2_0;
        unique case (sel)
            3'h0: k = tcpwm_pkg::DIV_LOG2_0;
            3'h1: k = tcpwm_pkg::DIV_LOG2_1;
            3'h2: k = tcpwm_pkg::DIV_LOG2_2;
            3'h3: k = tcpwm_pkg::DIV_LOG2_3;
            3'h4: k = tcpwm_pkg::DIV_LOG2_4;
            3'h5: k = tcpwm_pkg::DIV_LOG2_5;
            3'h6: k = tcpwm_pkg::DIV_LOG2_6;
            3'h7: k = tcpwm_pkg::DIV_LOG2_7;
        endcase
        return k;
    endfunction

    // One cycle in every 2^k: the low k prescaler bits are all ones
    function automatic logic tap_pulse(input logic [PRESC_W-1:0] presc, input logic [2:0] sel);
        logic [PRESC_W-1:0] mask;
        mask = PRESC_W'((PRESC_W+1)'(1) << div_log2(sel)) - PRESC_W'(1);
        return (presc & mask) == mask;
    endfunction

    // Next counter value, wrapping after the last count
    function automatic logic [7:0] count_step(input logic [7:0] cnt);
        return (cnt == tcpwm_pkg::COUNT_LAST) ? tcpwm_pkg::COUNT_FIRST : cnt + 8'h01;
    endfunction

    // Write strobe aimed at one register of the selected channel
    function automatic logic wr_hit(input logic wr, input logic sel, input logic [1:0] off, input logic [1:0] want);
        return wr && sel && (off == want);
    endfunction

    // Free-running prescaler shared by all channels
    logic [PRESC_W-1:0] presc_reg;
    logic [PRESC_W-1:0] presc_next;

    assign presc_next = STANDBY ? '0 : presc_reg + PRESC_W'(1);

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            presc_reg <= '0;
        end else begin
            presc_reg <= presc_next;
        end
    end

    // Address decode
    logic addr_in_block;
    logic [15:0] addr_rel;
    logic [1:0] addr_ch;
    logic [1:0] addr_off;
    logic addr_hit;

    assign addr_rel = REG_ADDR - tcpwm_pkg::CH_BASE;
    assign addr_ch = addr_rel[3:2];
    assign addr_off = addr_rel[1:0];
    assign addr_in_block = (REG_ADDR >= tcpwm_pkg::CH_BASE) && (addr_rel[15:4] == 12'h000);
    assign addr_hit = addr_in_block && (addr_ch < 2'(NCH)) && (addr_off != 2'h3);

    // Per-channel state
    logic [7:0] ctrl_reg [NCH];
    logic [7:0] duty_act_reg [NCH];
    logic [7:0] duty_pend_reg [NCH];
    logic [7:0] cnt_reg [NCH];
    logic pulse_reg [NCH];
    logic [NCH-1:0] pin_out;
    logic [NCH-1:0] pin_oe;

    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch++) begin : g_ch
            logic sel_ch;
            logic wr_ctrl;
            logic wr_duty;
            logic wr_cnt;
            logic run;
            logic pol;
            logic tick;
            logic wrap;
            logic [7:0] cnt_inc;
            logic [7:0] duty_eff;
            logic [7:0] ctrl_next;
            logic [7:0] duty_act_next;
            logic [7:0] duty_pend_next;
            logic [7:0] cnt_next;
            logic pulse_step;
            logic pulse_next;
            logic drive_pulse;

            assign sel_ch = addr_hit && (addr_ch == 2'(ch));
            assign wr_ctrl = wr_hit(REG_WR, sel_ch, addr_off, tcpwm_pkg::OFF_CONTROL);
            assign wr_duty = wr_hit(REG_WR, sel_ch, addr_off, tcpwm_pkg::OFF_DUTY);
            assign wr_cnt = wr_hit(REG_WR, sel_ch, addr_off, tcpwm_pkg::OFF_COUNTER);

            assign run = ctrl_reg[ch][tcpwm_pkg::CTL_RUN_BIT];
            assign pol = ctrl_reg[ch][tcpwm_pkg::CTL_POL_BIT];
            assign tick = run && tap_pulse(presc_reg, ctrl_reg[ch][tcpwm_pkg::CTL_CKS_HI:tcpwm_pkg::CTL_CKS_LO]);
            assign cnt_inc = count_step(cnt_reg[ch]);
            assign wrap = tick && (cnt_reg[ch] == tcpwm_pkg::COUNT_LAST);

            // Reserved bits stay one whatever is written
            assign ctrl_next = (REG_WDATA & tcpwm_pkg::CTL_WR_MASK) | tcpwm_pkg::CTL_RSV_MASK;

            // Counter: cleared while stopped, test write beats a step
            always_comb begin
                cnt_next = cnt_reg[ch];
                if (!run) begin
                    cnt_next = tcpwm_pkg::COUNTER_RESET;
                end else if (wr_cnt) begin
                    cnt_next = REG_WDATA;
                end else if (tick) begin
                    cnt_next = cnt_inc;
                end
            end

            // Double-buffered duty
            always_comb begin
                duty_pend_next = duty_pend_reg[ch];
                duty_act_next = duty_act_reg[ch];
                if (wr_duty) begin
                    duty_pend_next = REG_WDATA;
                end
                if (wr_duty && !run) begin
                    duty_act_next = REG_WDATA;
                end else if (wrap) begin
                    duty_act_next = wr_duty ? REG_WDATA : duty_pend_reg[ch];
                end
            end

            // Duty used for the step that is taking place
            assign duty_eff = wrap ? duty_act_next : duty_act_reg[ch];

            // Internal pulse on each counter step
            always_comb begin
                pulse_step = pulse_reg[ch];
                if (duty_eff == tcpwm_pkg::DUTY_ZERO) begin
                    pulse_step = 1'b0;
                end else if (duty_eff >= tcpwm_pkg::DUTY_FULL) begin
                    pulse_step = 1'b1;
                end else if (cnt_inc == duty_eff) begin
                    pulse_step = 1'b0;
                end else if (cnt_inc == tcpwm_pkg::COUNT_SET) begin
                    pulse_step = 1'b1;
                end
            end

            always_comb begin
                pulse_next = pulse_reg[ch];
                if (!run) begin
                    pulse_next = 1'b0;
                end else if (tick && !wr_cnt) begin
                    pulse_next = pulse_step;
                end
            end

            // Standby reinitialises like reset, but only on a clock edge
            always_ff @(posedge CLOCK or negedge RST_B) begin
                if (!RST_B) begin
                    ctrl_reg[ch] <= tcpwm_pkg::CONTROL_RESET;
                end else if (STANDBY) begin
                    ctrl_reg[ch] <= tcpwm_pkg::CONTROL_RESET;
                end else if (wr_ctrl) begin
                    ctrl_reg[ch] <= ctrl_next;
                end
            end

            always_ff @(posedge CLOCK or negedge RST_B) begin
                if (!RST_B) begin
                    duty_act_reg[ch] <= tcpwm_pkg::DUTY_RESET;
                end else if (STANDBY) begin
                    duty_act_reg[ch] <= tcpwm_pkg::DUTY_RESET;
                end else begin
                    duty_act_reg[ch] <= duty_act_next;
                end
            end

            always_ff @(posedge CLOCK or negedge RST_B) begin
                if (!RST_B) begin
                    duty_pend_reg[ch] <= tcpwm_pkg::DUTY_RESET;
                end else if (STANDBY) begin
                    duty_pend_reg[ch] <= tcpwm_pkg::DUTY_RESET;
                end else begin
                    duty_pend_reg[ch] <= duty_pend_next;
                end
            end

            always_ff @(posedge CLOCK or negedge RST_B) begin
                if (!RST_B) begin
                    cnt_reg[ch] <= tcpwm_pkg::COUNTER_RESET;
                end else if (STANDBY) begin
                    cnt_reg[ch] <= tcpwm_pkg::COUNTER_RESET;
                end else begin
                    cnt_reg[ch] <= cnt_next;
                end
            end

            always_ff @(posedge CLOCK or negedge RST_B) begin
                if (!RST_B) begin
                    pulse_reg[ch] <= 1'b0;
                end else if (STANDBY) begin
                    pulse_reg[ch] <= 1'b0;
                end else begin
                    pulse_reg[ch] <= pulse_next;
                end
            end

            // Pin: pulse logic only when enabled and routed, else the port register
            assign drive_pulse = run && PORT9_PULSE_ROUTE_EN && !PORT9_SERIAL_ROUTE_EN;
            assign pin_out[ch] = drive_pulse ? (pulse_reg[ch] ^ pol) : PORT9_DATA[ch];
            assign pin_oe[ch] = drive_pulse ? 1'b1 : PORT9_DIR[ch];
        end
    endgenerate

    assign PULSE_OUT_CH1 = pin_out[0];
    assign PULSE_OE_CH1 = pin_oe[0];
    assign PULSE_OUT_CH2 = pin_out[1];
    assign PULSE_OE_CH2 = pin_oe[1];
    assign PULSE_OUT_CH3 = pin_out[2];
    assign PULSE_OE_CH3 = pin_oe[2];

    // Read path, answered in the cycle after the strobe
    logic [7:0] rd_mux;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [1:0] rd_ch;

    assign rd_ch = (addr_ch < 2'(NCH)) ? addr_ch : 2'h0;

    always_comb begin
        rd_mux = tcpwm_pkg::READ_UNMAPPED;
        if (addr_hit) begin
            unique case (addr_off)
                tcpwm_pkg::OFF_CONTROL: rd_mux = ctrl_reg[rd_ch] | tcpwm_pkg::CTL_RSV_MASK;
                tcpwm_pkg::OFF_DUTY: rd_mux = duty_act_reg[rd_ch];
                tcpwm_pkg::OFF_COUNTER: rd_mux = cnt_reg[rd_ch];
                default: rd_mux = tcpwm_pkg::READ_UNMAPPED;
            endcase
        end
    end

    assign rdata_next = REG_RD ? rd_mux : tcpwm_pkg::READ_UNMAPPED;

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            rdata_reg <= tcpwm_pkg::READ_UNMAPPED;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign REG_RDATA = rdata_reg;

endmodule

// ===== rtl/tcpwm_pkg.sv
// Constants shared by the three-channel pulse-width timer
package tcpwm_pkg;

    localparam int NUM_CH = 3;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int PRESC_W = 12;

    // Register map: channel n sits at CH_BASE + n * CH_STRIDE
    localparam logic [15:0] CH_BASE = 16'hFEC0;
    localparam logic [15:0] CH_STRIDE = 16'h0004;
    localparam logic [1:0] OFF_CONTROL = 2'h0;
    localparam logic [1:0] OFF_DUTY = 2'h1;
    localparam logic [1:0] OFF_COUNTER = 2'h2;
    localparam logic [15:0] CH1_PWM_CONTROL = 16'hFEC0;
    localparam logic [15:0] CH1_DUTY_COMPARE = 16'hFEC1;
    localparam logic [15:0] CH1_PERIOD_COUNTER = 16'hFEC2;
    localparam logic [15:0] CH2_PWM_CONTROL = 16'hFEC4;
    localparam logic [15:0] CH2_DUTY_COMPARE = 16'hFEC5;
    localparam logic [15:0] CH2_PERIOD_COUNTER = 16'hFEC6;
    localparam logic [15:0] CH3_PWM_CONTROL = 16'hFEC8;
    localparam logic [15:0] CH3_DUTY_COMPARE = 16'hFEC9;
    localparam logic [15:0] CH3_PERIOD_COUNTER = 16'hFECA;

    // Control register fields
    localparam int CTL_RUN_BIT = 7;
    localparam int CTL_POL_BIT = 6;
    localparam int CTL_RSV_HI = 5;
    localparam int CTL_RSV_LO = 3;
    localparam int CTL_CKS_HI = 2;
    localparam int CTL_CKS_LO = 0;
    localparam logic [7:0] CTL_RSV_MASK = 8'h38;
    localparam logic [7:0] CTL_WR_MASK = 8'hC7;

    // Reset values
    localparam logic [7:0] CONTROL_RESET = 8'h38;
    localparam logic [7:0] DUTY_RESET = 8'hFF;
    localparam logic [7:0] COUNTER_RESET = 8'h00;

    // Counting range and duty limits
    localparam logic [7:0] COUNT_FIRST = 8'h00;
    localparam logic [7:0] COUNT_SET = 8'h01;
    localparam logic [7:0] COUNT_LAST = 8'hF9;
    localparam logic [7:0] DUTY_ZERO = 8'h00;
    localparam logic [7:0] DUTY_FULL = 8'hFA;

    // Prescale select codes give divide-by 2^k with these k
    localparam logic [3:0] DIV_LOG2_0 = 4'h1;
    localparam logic [3:0] DIV_LOG2_1 = 4'h3;
    localparam logic [3:0] DIV_LOG2_2 = 4'h5;
    localparam logic [3:0] DIV_LOG2_3 = 4'h7;
    localparam logic [3:0] DIV_LOG2_4 = 4'h8;
    localparam logic [3:0] DIV_LOG2_5 = 4'hA;
    localparam logic [3:0] DIV_LOG2_6 = 4'hB;
    localparam logic [3:0] DIV_LOG2_7 = 4'hC;

    localparam logic [7:0] READ_UNMAPPED = 8'h00;

endpackage

// ===== tb/tcpwm_load.sv
// External load on one pulse pin: resolves the pin and totals its high time
module tcpwm_load (
    input wire logic clk,
    input wire logic clr,
    input wire logic pin_out,
    input wire logic pin_oe,
    output logic level,
    output logic [15:0] high_cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    // A released pin is pulled up on the board
    assign level = pin_oe ? pin_out : 1'b1;
    always_ff @(posedge clk) begin
        if (clr) begin
            high_cnt <= 16'h0000;
        end else begin
            high_cnt <= high_cnt + {15'h0000, level};
        end
    end
endmodule

// ===== tb/tcpwm_timer_properties.sv
// Checker on the register port and pin muxing of the pulse timer
module tcpwm_timer_properties #(
    parameter int PRESC_W = tcpwm_pkg::PRESC_W
) (
    input wire logic CLOCK,
    input wire logic RST_B,
    input wire logic STANDBY,
    input wire logic [15:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_RDATA,
    input wire logic PORT9_PULSE_ROUTE_EN,
    input wire logic PORT9_SERIAL_ROUTE_EN,
    input wire logic [2:0] PORT9_DATA,
    input wire logic [2:0] PORT9_DIR,
    input wire logic PULSE_OUT_CH1,
    input wire logic PULSE_OE_CH1,
    input wire logic PULSE_OUT_CH2,
    input wire logic PULSE_OE_CH2,
    input wire logic PULSE_OUT_CH3,
    input wire logic PULSE_OE_CH3
);
    timeunit 1ns;
    timeprecision 1ps;
    logic run1;
    wire rd_ctl = REG_RD && REG_ADDR[15:4] == 12'hFEC && REG_ADDR[1:0] == 2'h0 && REG_ADDR[3:2] != 2'h3;
    wire duty1 = REG_ADDR == tcpwm_pkg::CH1_DUTY_COMPARE;
    // Mirror of the channel one run bit
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            run1 <= 1'b0;
        end else if (STANDBY) begin
            run1 <= 1'b0;
        end else if (REG_WR && REG_ADDR == tcpwm_pkg::CH1_PWM_CONTROL) begin
            run1 <= REG_WDATA[tcpwm_pkg::CTL_RUN_BIT];
        end
    end
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_B);
    a_rdata_idle: assert property (REG_RDATA != 8'h00 |-> $past(REG_RD))
        else $error("read data outside its slot");
    a_rsv_ones: assert property (rd_ctl |=> REG_RDATA[5:3] == 3'b111)
        else $error("reserved control bits not ones");
    a_unmapped_zero: assert property (REG_RD && REG_ADDR[1:0] == 2'h3 |=> REG_RDATA == 8'h00)
        else $error("hole in map read nonzero");
    a_port_off: assert property (!PORT9_PULSE_ROUTE_EN |-> PULSE_OUT_CH1 == PORT9_DATA[0] && PULSE_OE_CH1 == PORT9_DIR[0])
        else $error("unrouted pin not port");
    a_serial_blocks: assert property (PORT9_SERIAL_ROUTE_EN |-> PULSE_OE_CH2 == PORT9_DIR[1] && PULSE_OUT_CH2 == PORT9_DATA[1])
        else $error("serial route still pulses");
    a_standby_port: assert property ($past(STANDBY) |-> PULSE_OE_CH3 == PORT9_DIR[2] && PULSE_OUT_CH3 == PORT9_DATA[2])
        else $error("pin driven after standby");
    a_duty_now: assert property (REG_WR && duty1 && !run1 && !STANDBY ##1 !REG_WR ##1 REG_RD && duty1
        |=> REG_RDATA == $past(REG_WDATA, 3))
        else $error("stopped duty write not active");
    a_run_drives: assert property (run1 && PORT9_PULSE_ROUTE_EN && !PORT9_SERIAL_ROUTE_EN |-> PULSE_OE_CH1)
        else $error("running channel not driving");
endmodule
bind tcpwm_timer tcpwm_timer_properties #(.PRESC_W(PRESC_W)) tcpwm_timer_properties_i (.CLOCK(CLOCK), .RST_B(RST_B),
    .STANDBY(STANDBY), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .PORT9_PULSE_ROUTE_EN(PORT9_PULSE_ROUTE_EN), .PORT9_SERIAL_ROUTE_EN(PORT9_SERIAL_ROUTE_EN),
    .PORT9_DATA(PORT9_DATA), .PORT9_DIR(PORT9_DIR), .PULSE_OUT_CH1(PULSE_OUT_CH1), .PULSE_OE_CH1(PULSE_OE_CH1),
    .PULSE_OUT_CH2(PULSE_OUT_CH2), .PULSE_OE_CH2(PULSE_OE_CH2), .PULSE_OUT_CH3(PULSE_OUT_CH3), .PULSE_OE_CH3(PULSE_OE_CH3));

// ===== tb/test_tcpwm_timer.sv
// Self-checking bench for the three-channel pulse-width timer
module test_tcpwm_timer;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLOCK = 1'b0;
    logic RST_B = 1'b0;
    logic STANDBY = 1'b0;
    logic [15:0] REG_ADDR = 16'h0000;
    logic [7:0] REG_WDATA = 8'h00;
    logic REG_WR = 1'b0;
    logic REG_RD = 1'b0;
    logic [7:0] REG_RDATA;
    logic PORT9_PULSE_ROUTE_EN = 1'b1;
    logic PORT9_SERIAL_ROUTE_EN = 1'b0;
    logic [2:0] PORT9_DATA = 3'h0;
    logic [2:0] PORT9_DIR = 3'h0;
    logic [2:0] pout;
    logic [2:0] poe;
    logic [2:0] lvl;
    logic [2:0][15:0] hc;
    logic clr = 1'b0;
    int num_errors = 0;
    int n_tests = 0;
    always #12.5 CLOCK = ~CLOCK;
    tcpwm_timer tcpwm_timer_i (.CLOCK(CLOCK), .RST_B(RST_B), .STANDBY(STANDBY), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
        .PORT9_PULSE_ROUTE_EN(PORT9_PULSE_ROUTE_EN), .PORT9_SERIAL_ROUTE_EN(PORT9_SERIAL_ROUTE_EN),
        .PORT9_DATA(PORT9_DATA), .PORT9_DIR(PORT9_DIR), .PULSE_OUT_CH1(pout[0]), .PULSE_OE_CH1(poe[0]),
        .PULSE_OUT_CH2(pout[1]), .PULSE_OE_CH2(poe[1]), .PULSE_OUT_CH3(pout[2]), .PULSE_OE_CH3(poe[2]));
    for (genvar g = 0; g < 3; g++) begin : ld
        tcpwm_load tcpwm_load_i (.clk(CLOCK), .clr(clr), .pin_out(pout[g]), .pin_oe(poe[g]), .level(lvl[g]),
            .high_cnt(hc[g]));
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [15:0] adr(input int n, input logic [1:0] off);
        return tcpwm_pkg::CH_BASE + 16'(n) * tcpwm_pkg::CH_STRIDE + {14'h0000, off};
    endfunction
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge CLOCK);
        REG_WR <= 1'b1;
        REG_ADDR <= a;
        REG_WDATA <= d;
        @(posedge CLOCK);
        REG_WR <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge CLOCK);
        REG_RD <= 1'b1;
        REG_ADDR <= a;
        @(posedge CLOCK);
        REG_RD <= 1'b0;
        #1;
        chk({8'h00, REG_RDATA}, {8'h00, e});
    endtask
    // High cycles seen on each pin over a window
    task automatic meas(input int span, input logic [15:0] e1, input logic [15:0] e2, input logic [15:0] e3);
        @(posedge CLOCK);
        clr <= 1'b1;
        @(posedge CLOCK);
        clr <= 1'b0;
        repeat (span) @(posedge CLOCK);
        #1;
        chk(hc[0], e1);
        chk(hc[1], e2);
        chk(hc[2], e3);
    endtask
    task automatic t_reset;
        for (int n = 0; n < 3; n++) begin
            rd(adr(n, 2'h0), 8'h38);
            rd(adr(n, 2'h1), 8'hFF);
            rd(adr(n, 2'h2), 8'h00);
        end
        rd(16'hFEC3, 8'h00);
        chk({13'h0000, lvl}, 16'h0007);
    endtask
    task automatic t_ctrl_duty;
        wr(adr(0, 2'h0), 8'h47);
        rd(adr(0, 2'h0), 8'h7F);
        wr(adr(0, 2'h0), 8'h00);
        rd(adr(0, 2'h0), 8'h38);
        wr(adr(0, 2'h1), 8'h55);
        rd(adr(0, 2'h1), 8'h55);
    endtask
    task automatic t_pulse;
        logic [7:0] duty [3] = '{8'h7D, 8'h00, 8'hFA};
        logic [7:0] ctl [3] = '{8'h80, 8'hC0, 8'h80};
        for (int n = 0; n < 3; n++) begin
            wr(adr(n, 2'h1), duty[n]);
            wr(adr(n, 2'h0), ctl[n]);
        end
        repeat (600) @(posedge CLOCK);
        meas(500, 16'h00F8, 16'h01F4, 16'h01F4);
    endtask
    task automatic t_buffer;
        wr(adr(0, 2'h1), 8'h20);
        rd(adr(0, 2'h1), 8'h7D);
        repeat (600) @(posedge CLOCK);
        rd(adr(0, 2'h1), 8'h20);
        meas(500, 16'h003E, 16'h01F4, 16'h01F4);
    endtask
    task automatic t_presc;
        int div;
        for (int c = 1; c < 3; c++) begin
            div = 2 ** (2 * c + 1);
            wr(adr(0, 2'h0), 8'h00);
            rd(adr(0, 2'h2), 8'h00);
            wr(adr(0, 2'h0), 8'h80 | 8'(c));
            repeat (300 * div) @(posedge CLOCK);
            meas(250 * div, 16'(div * (8'h20 - 1)), 16'(250 * div), 16'(250 * div));
        end
    endtask
    // Codes 3 to 7: a window of two counting-clock periods from enable gives a count of two
    task automatic t_codes;
        int divs [5] = '{128, 256, 1024, 2048, 4096};
        for (int c = 0; c < 5; c++) begin
            wr(adr(0, 2'h0), 8'h00);
            wr(adr(0, 2'h0), 8'h80 | 8'(c + 3));
            repeat (2 * divs[c] - 1) @(posedge CLOCK);
            rd(adr(0, 2'h2), 8'h02);
        end
    endtask
    task automatic t_route;
        @(posedge CLOCK);
        PORT9_DIR <= 3'h7;
        PORT9_SERIAL_ROUTE_EN <= 1'b1;
        meas(500, 16'h0000, 16'h0000, 16'h0000);
        @(posedge CLOCK);
        PORT9_SERIAL_ROUTE_EN <= 1'b0;
        PORT9_PULSE_ROUTE_EN <= 1'b0;
        PORT9_DATA <= 3'h5;
        meas(500, 16'h01F4, 16'h0000, 16'h01F4);
        @(posedge CLOCK);
        PORT9_PULSE_ROUTE_EN <= 1'b1;
        PORT9_DATA <= 3'h0;
        wr(adr(0, 2'h0), 8'h00);
        wr(adr(1, 2'h0), 8'h40);
        meas(500, 16'h0000, 16'h0000, 16'h01F4);
    endtask
    task automatic t_standby;
        @(posedge CLOCK);
        STANDBY <= 1'b1;
        wr(adr(2, 2'h1), 8'h10);
        STANDBY <= 1'b0;
        rd(adr(2, 2'h0), 8'h38);
        rd(adr(2, 2'h1), 8'hFF);
        rd(adr(2, 2'h2), 8'h00);
    endtask
    task automatic wrap_up;
        $display("errors %0d, checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge CLOCK);
        RST_B <= 1'b1;
        t_reset;
        t_ctrl_duty;
        t_pulse;
        t_buffer;
        t_presc;
        t_codes;
        t_route;
        t_standby;
        wrap_up;
    end
    initial begin
        repeat (60000) @(posedge CLOCK);
        num_errors++;
        wrap_up;
    end
endmodule
